// ===== pkg/bmscp_map.vh
`ifndef BMSCP_MAP_VH
`define BMSCP_MAP_VH

// Register byte offsets (word aligned)
`define BMSCP_OFS_CMD       8'h00
`define BMSCP_OFS_CTRL      8'h04
`define BMSCP_OFS_RESULT    8'h08
`define BMSCP_OFS_FLAGS     8'h0c
`define BMSCP_OFS_IRQ_STAT  8'h10
`define BMSCP_OFS_IRQ_MASK  8'h14

// Control register bits
`define BMSCP_CTRL_GO        0
`define BMSCP_CTRL_FCLR      1
`define BMSCP_CTRL_DISCH     2
`define BMSCP_CTRL_ALLOW_PS  3
`define BMSCP_CTRL_SETTLE    4
`define BMSCP_CTRL_RETRY     5

// Interrupt status bits
`define BMSCP_IRQ_DONE       0
`define BMSCP_IRQ_FAULT      1
`define BMSCP_IRQ_CLR_FAIL   2
`define BMSCP_IRQ_W          3

// Command word field positions (first byte in [31:24])
`define BMSCP_CMD_START_BIT  25
`define BMSCP_CMD_BIT_ORDER_SELECT_BIT   21
`define BMSCP_CMD_PS_BIT     13
`define BMSCP_CMD_FCLR_BIT   9
`define BMSCP_CMD_TO0_BIT    8
`define BMSCP_CMD_TO1_BIT    7
`define BMSCP_CMD_TO2_BIT    6

// Exchange framing
`define BMSCP_FRAME_BITS     48
`define BMSCP_LAST_BIT       6'd47
`define BMSCP_DUMMY_BYTES    16'h0000

// Timing
`define BMSCP_CLK_MHZ        100
`define BMSCP_SCK_HALF       4'd8
`define BMSCP_SETTLE_MS      1000

`endif

// ===== hdl/bmscp_host.v
`include "bmscp_map.vh"

module bmscp_host #(
    parameter [31:0] SETTLE_CYCLES = `BMSCP_SETTLE_MS * `BMSCP_CLK_MHZ * 1000
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Serial link to the battery manager
    output reg         link_cs_n,
    output reg         link_sck,
    output reg         link_mosi,
    input  wire        link_miso,
    // Interrupt
    output reg         irq
);

    localparam S_IDLE   = 3'd0;
    localparam S_SETTLE = 3'd1;
    localparam S_SETUP  = 3'd2;
    localparam S_SHIFT  = 3'd3;
    localparam S_HOLD   = 3'd4;

    reg  [2:0]               state_r;
    reg  [31:0]              cmd_r;
    reg  [5:1]               ctrl_r;
    reg  [31:0]              tx_r;
    reg  [`BMSCP_FRAME_BITS-1:0] rx_r;
    reg  [9:0]               result_r;
    reg  [7:0]               flags_r;
    reg  [`BMSCP_IRQ_W-1:0]  irq_stat_r;
    reg  [`BMSCP_IRQ_W-1:0]  irq_mask_r;
    reg  [3:0]               div_r;
    reg  [5:0]               bit_r;
    reg  [31:0]              settle_r;
    reg                      fclr_now_r;
    reg                      retry_en_r;
    reg                      retried_r;
    reg                      aw_got_r;
    reg                      w_got_r;
    reg                      miso_s1_r;
    reg                      miso_s2_r;
    reg  [7:0]               aw_addr_r;
    reg  [31:0]              w_data_r;
    reg  [3:0]               w_strb_r;
    reg  [`BMSCP_IRQ_W-1:0]  irq_set;
    reg  [`BMSCP_IRQ_W-1:0]  irq_clr;
    reg  [31:0]              rd_mux;
    reg  [31:0]              launch_cmd;
    wire                     wr_fire;
    wire                     go_req;
    wire                     half_done;
    wire                     bit_order_select;
    wire [`BMSCP_FRAME_BITS-1:0] tx_frame;
    integer                  i;

    // Bit n of the frame maps to a fixed position of the canonical word
    function [5:0] frame_pos;
        input [5:0] n;
        input       msb_first;
        begin
            frame_pos = `BMSCP_LAST_BIT - {n[5:3], 3'b000} - (msb_first ? {3'b000, n[2:0]} : {3'b000, ~n[2:0]});
        end
    endfunction

    assign wr_fire   = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign go_req    = wr_fire & (aw_addr_r == `BMSCP_OFS_CTRL) & w_strb_r[0] & w_data_r[`BMSCP_CTRL_GO];
    assign half_done = (div_r == `BMSCP_SCK_HALF - 4'd1);
    assign bit_order_select      = tx_r[`BMSCP_CMD_BIT_ORDER_SELECT_BIT];
    assign tx_frame  = {tx_r, `BMSCP_DUMMY_BYTES};

    // Command as sent: software fields with forced framing and safety bits
    always @* begin
        launch_cmd = cmd_r;
        launch_cmd[31:26] = 6'h00;
        launch_cmd[3:0] = 4'h0;
        launch_cmd[`BMSCP_CMD_START_BIT] = 1'b1;
        if (!w_data_r[`BMSCP_CTRL_ALLOW_PS]) begin
            launch_cmd[`BMSCP_CMD_PS_BIT] = 1'b0;
        end
        launch_cmd[`BMSCP_CMD_FCLR_BIT] = w_data_r[`BMSCP_CTRL_FCLR];
        if (w_data_r[`BMSCP_CTRL_DISCH]) begin
            launch_cmd[`BMSCP_CMD_TO0_BIT] = 1'b1;
            launch_cmd[`BMSCP_CMD_TO1_BIT] = 1'b1;
            launch_cmd[`BMSCP_CMD_TO2_BIT] = 1'b1;
        end
    end

    always @* begin
        case (s_axi_araddr)
            `BMSCP_OFS_CMD:      rd_mux = cmd_r;
            `BMSCP_OFS_CTRL:     rd_mux = {26'h0000000, ctrl_r, state_r != S_IDLE};
            `BMSCP_OFS_RESULT:   rd_mux = {22'h000000, result_r};
            `BMSCP_OFS_FLAGS:    rd_mux = {24'h000000, flags_r};
            `BMSCP_OFS_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_r};
            `BMSCP_OFS_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_r};
            default:             rd_mux = 32'h00000000;
        endcase
    end

    always @* begin
        irq_clr = {`BMSCP_IRQ_W{1'b0}};
        if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `BMSCP_OFS_IRQ_STAT) begin
            irq_clr = {`BMSCP_IRQ_W{1'b1}};
        end
    end

    always @* begin
        irq_set = {`BMSCP_IRQ_W{1'b0}};
        if (state_r == S_HOLD && half_done) begin
            irq_set[`BMSCP_IRQ_DONE]  = 1'b1;
            irq_set[`BMSCP_IRQ_FAULT] = |rx_r[6:0];
            irq_set[`BMSCP_IRQ_CLR_FAIL] = fclr_now_r & (|rx_r[6:0]);
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'b00;
            s_axi_rdata   <= 32'h00000000;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h00000000;
            w_strb_r      <= 4'h0;
            cmd_r         <= 32'h00000000;
            ctrl_r        <= 5'h00;
            irq_mask_r    <= {`BMSCP_IRQ_W{1'b0}};
            irq_stat_r    <= {`BMSCP_IRQ_W{1'b0}};
            irq           <= 1'b0;
            state_r       <= S_IDLE;
            tx_r          <= 32'h00000000;
            rx_r          <= {`BMSCP_FRAME_BITS{1'b0}};
            result_r      <= 10'h000;
            flags_r       <= 8'h00;
            div_r         <= 4'h0;
            bit_r         <= 6'h00;
            settle_r      <= 32'h00000000;
            fclr_now_r    <= 1'b0;
            retry_en_r    <= 1'b0;
            retried_r     <= 1'b0;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            miso_s1_r     <= 1'b0;
            miso_s2_r     <= 1'b0;
            link_cs_n     <= 1'b1;
            link_sck      <= 1'b0;
            link_mosi     <= 1'b0;
        end else begin
            miso_s1_r <= link_miso;
            miso_s2_r <= miso_s1_r;

            // Write channel: address and data taken in either order
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
                aw_got_r      <= 1'b1;
            end else if (!aw_got_r && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
                w_got_r      <= 1'b1;
            end else if (!w_got_r && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                if (aw_addr_r == `BMSCP_OFS_CMD) begin
                    for (i = 0; i < 4; i = i + 1) begin
                        if (w_strb_r[i]) begin
                            cmd_r[8*i +: 8] <= w_data_r[8*i +: 8];
                        end
                    end
                end
                if (aw_addr_r == `BMSCP_OFS_CTRL && w_strb_r[0]) begin
                    ctrl_r <= w_data_r[5:1];
                end
                if (aw_addr_r == `BMSCP_OFS_IRQ_MASK && w_strb_r[0]) begin
                    irq_mask_r <= w_data_r[`BMSCP_IRQ_W-1:0];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
            end

            // Read channel
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'b00;
                s_axi_rdata   <= rd_mux;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end

            // Link sequencer
            case (state_r)
                S_IDLE: begin
                    div_r <= 4'h0;
                    // A go while busy is dropped, not queued
                    if (go_req) begin
                        tx_r       <= launch_cmd;
                        fclr_now_r <= w_data_r[`BMSCP_CTRL_FCLR];
                        retry_en_r <= w_data_r[`BMSCP_CTRL_RETRY];
                        retried_r  <= 1'b0;
                        ctrl_r[`BMSCP_CTRL_FCLR] <= 1'b0;
                        settle_r   <= 32'h00000000;
                        state_r    <= w_data_r[`BMSCP_CTRL_SETTLE] ? S_SETTLE : S_SETUP;
                    end
                end
                S_SETTLE: begin
                    settle_r <= settle_r + 32'h00000001;
                    if (settle_r >= SETTLE_CYCLES - 32'h00000001) begin
                        state_r <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    link_cs_n <= 1'b0;
                    link_sck  <= 1'b0;
                    bit_r     <= 6'h00;
                    link_mosi <= tx_frame[frame_pos(6'h00, bit_order_select)];
                    div_r     <= half_done ? 4'h0 : div_r + 4'h1;
                    if (half_done) begin
                        state_r <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    div_r <= half_done ? 4'h0 : div_r + 4'h1;
                    if (half_done && !link_sck) begin
                        link_sck <= 1'b1;
                    end else if (half_done) begin
                        link_sck <= 1'b0;
                        rx_r[frame_pos(bit_r, bit_order_select)] <= miso_s2_r;
                        if (bit_r == `BMSCP_LAST_BIT) begin
                            state_r <= S_HOLD;
                        end else begin
                            bit_r     <= bit_r + 6'h01;
                            link_mosi <= tx_frame[frame_pos(bit_r + 6'h01, bit_order_select)];
                        end
                    end
                end
                S_HOLD: begin
                    link_mosi <= 1'b0;
                    div_r     <= half_done ? 4'h0 : div_r + 4'h1;
                    if (half_done) begin
                        link_cs_n <= 1'b1;
                        result_r  <= rx_r[17:8];
                        flags_r   <= rx_r[7:0];
                        if (fclr_now_r && retry_en_r && !retried_r && (|rx_r[6:0])) begin
                            retried_r <= 1'b1;
                            settle_r  <= 32'h00000000;
                            state_r   <= S_SETTLE;
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state_r   <= S_IDLE;
                    link_cs_n <= 1'b1;
                    link_sck  <= 1'b0;
                end
            endcase

            // New events win over a read clear in the same cycle
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq        <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
        end
    end
endmodule // bmscp_host

// ===== tb/bmscp_chk.sv
module bmscp_chk (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Serial link
    input logic link_cs_n,
    input logic link_sck,
    input logic link_mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sck_r;
    logic       lsb_r;
    logic [5:0] cnt_r;
    wire        rise = link_sck & ~sck_r;

    // Count serial clock rises within a frame
    always @(posedge aclk) begin
        sck_r <= link_sck;
        cnt_r <= (!aresetn || link_cs_n) ? 6'h00 : cnt_r + {5'h00, rise};
        if (rise && cnt_r == 6'h01) lsb_r <= link_mosi;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sck_idle_low: assert property (link_cs_n |-> !link_sck)
        else $error("serial clock active while deselected");
    a_cs_lead: assert property ($fell(link_cs_n) |-> !link_sck [*8] ##1 !link_sck [*7] ##1 link_sck)
        else $error("first clock rise not 15 cycles after select");
    a_sck_high: assert property ($rose(link_sck) |-> link_sck [*8] ##1 !link_sck)
        else $error("serial clock high phase not 8 cycles");
    a_mosi_hold: assert property (link_sck |-> $stable(link_mosi))
        else $error("command bit moved while clock high");
    a_frame_len: assert property ($rose(link_cs_n) |-> cnt_r == 6'h30)
        else $error("frame length not 48 bits");
    a_pad_zero: assert property (rise && cnt_r > 6'h01 && cnt_r < 6'h06 |-> !link_mosi)
        else $error("leading padding bit not zero");
    a_dummy_zero: assert property (rise && cnt_r > 6'h1f |-> !link_mosi)
        else $error("dummy byte bit not zero");
    a_start_one: assert property (rise && cnt_r == 6'h06 |-> link_mosi != lsb_r)
        else $error("start bit not sent as one");
    a_bit_order: assert property (rise && cnt_r == (lsb_r ? 6'h0d : 6'h0a) |-> link_mosi == !lsb_r)
        else $error("bit order differs from order select bit");
    a_cs_tail: assert property ($fell(link_sck) && cnt_r == 6'h30 |-> !link_cs_n [*8] ##1 link_cs_n)
        else $error("deselect not 8 cycles after last fall");

    c_frame: cover property ($rose(link_cs_n));
    c_lsb: cover property (rise && cnt_r == 6'h0d && lsb_r);
    c_msb: cover property (rise && cnt_r == 6'h0a && !lsb_r);
endmodule // bmscp_chk

bind bmscp_host bmscp_chk u_chk (.aclk, .aresetn, .link_cs_n, .link_sck, .link_mosi);

// ===== tb/bmscp_dev.sv
module bmscp_dev (
    // Serial link
    input  logic        link_cs_n,
    input  logic        link_sck,
    input  logic        link_mosi,
    output logic        link_miso,
    // Bench side
    input  logic [9:0]  res_v,
    input  logic [7:0]  flt_v,
    input  logic [6:0]  stk_v,
    output logic [31:0] cmd_seen,
    output int          frames
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [47:0] arr;
    int          idx = 0;

    initial begin
        link_miso = 1'b0;
        frames = 0;
    end

    // order from padding
    // Padding leaves only one legal slot for the start bit, so it reveals the order
    function automatic logic [7:0] canon(input int k);
        for (int j = 0; j < 8; j++) canon[arr[1] ? j : 7 - j] = arr[8 * k + j];
    endfunction

    // status byte
    // Faults in stk_v survive a clear, so a failed clear can be staged
    function automatic logic tx_bit(input int i);
        logic [7:0] b;
        logic [7:0] c;
        c = canon(2);
        case (i / 8)
            3: b = {5'h15, 1'b0, res_v[9:8]};
            4: b = res_v[7:0];
            5: b = {flt_v[7], c[1] ? flt_v[6:0] & stk_v : flt_v[6:0]};
            default: b = {8{i[0]}};
        endcase
        tx_bit = b[arr[1] ? i % 8 : 7 - i % 8];
    endfunction

    always @(negedge link_cs_n) begin
        idx = 0;
        link_miso = tx_bit(0);
    end

    always @(posedge link_sck)
        if (!link_cs_n && idx < 48) begin
            arr[idx] = link_mosi;
            idx++;
        end

    always @(negedge link_sck)
        if (!link_cs_n && idx < 48) link_miso = tx_bit(idx);

    always @(posedge link_cs_n) begin
        if (idx == 48) begin
            cmd_seen = {canon(0), canon(1), canon(2), canon(3)};
            frames++;
        end
        idx = 0;
        link_miso = ~link_miso;
    end
endmodule // bmscp_dev

// ===== tb/test_bmscp_host.sv
`include "bmscp_map.vh"
module test_bmscp_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata, cmd_seen;
    wire         link_cs_n, link_sck, link_mosi, link_miso, irq;
    logic [9:0]  res_v = 10'h0;
    logic [7:0]  flt_v = 8'h0;
    logic [6:0]  stk_v = 7'h0;
    int          frames;
    int          bad_count = 0;
    int          num_checks = 0;
    logic [31:0] seed = 32'h87da7d3a;

    bmscp_host #(.SETTLE_CYCLES(32'd20)) u_bmscp_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .link_cs_n, .link_sck, .link_mosi, .link_miso, .irq);
    bmscp_dev u_bmscp_dev (.link_cs_n, .link_sck, .link_mosi, .link_miso, .res_v, .flt_v, .stk_v,
        .cmd_seen, .frames);

    always #5 aclk = ~aclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] exp_cmd(input logic [31:0] c, input logic [31:0] ct);
        exp_cmd = {6'h00, 1'b1, c[24:0]};
        exp_cmd[3:0] = 4'h0;
        exp_cmd[13] = c[13] & ct[3];
        exp_cmd[9] = ct[1];
        if (ct[2]) exp_cmd[8:6] = 3'h7;
    endfunction

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            bad_count++;
            $display("mismatch wait expected answer seen timeout");
            finish_test;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        s_axi_bready <= 1'b0;
        guard(n, 200);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        guard(n, 200);
    endtask

    initial begin : main
        logic [31:0] c, ct, v, st;
        logic [7:0]  fl;
        logic [2:0]  m;
        int          n, f0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        wr(8'h18, rnd());
        rd(8'h18, v);
        chk("unmapped", v, 32'h0);
        for (int i = 0; i < 10; i++) begin
            c = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : rnd();
            ct = (i == 0) ? 32'h22 : (i == 1) ? 32'h0 : rnd() & 32'h3e;
            m = 3'(rnd());
            res_v <= 10'(rnd());
            flt_v <= (i == 1) ? 8'h80 : (i == 0) ? 8'hff : 8'(rnd());
            stk_v <= (i == 0) ? 7'h7f : 7'(rnd());
            f0 = frames;
            wr(`BMSCP_OFS_IRQ_MASK, {29'h0, m});
            wr(`BMSCP_OFS_CMD, c);
            wr(`BMSCP_OFS_CTRL, ct | 32'h1);
            // A second go during the settle wait must be ignored
            if (i == 2) wr(`BMSCP_OFS_CTRL, ct | 32'h1);
            n = 0;
            do begin
                rd(`BMSCP_OFS_CTRL, v);
                n++;
            end while (v[0] && n < 1000);
            guard(n, 1000);
            fl = ct[1] ? {flt_v[7], flt_v[6:0] & stk_v} : flt_v;
            st = {29'h0, ct[1] & |fl[6:0], |fl[6:0], 1'b1};
            chk("frames", 32'(frames - f0), 32'(1 + (ct[1] & ct[5] & |fl[6:0])));
            chk("command", cmd_seen, exp_cmd(c, ct));
            rd(`BMSCP_OFS_RESULT, v);
            chk("result", v, {22'h0, res_v});
            rd(`BMSCP_OFS_FLAGS, v);
            chk("flags", v, {24'h0, fl});
            chk("irq", {31'h0, irq}, {31'h0, |(st[2:0] & m)});
            rd(`BMSCP_OFS_IRQ_STAT, v);
            chk("status", v, st);
            repeat (3) @(posedge aclk);
            chk("irq clear", {31'h0, irq}, 32'h0);
        end
        finish_test;
    end
endmodule // test_bmscp_host
